// ===== hw/wdg_pkg.sv
// package for the watchdog pulse and chip-enable gate block
// assumes a 100 MHz clock; all intervals become cycle counts
package wdg_pkg;

	// ===========================================================
	// clock and timing
	localparam int CLK_HZ           = 100_000_000;
	localparam int CLK_NS           = 10;
	localparam int PULSE_US         = 1700;    // 1.7ms prewarn pulse
	localparam int FAULT_DELAY_NS   = 70;      // fault lags pulse edge
	localparam int WRITE_HOLD_NS    = 15_000;  // 15us write completion
	localparam int KICK_MIN_NS      = 100;     // least kick pulse
	localparam int DEF_TIMEOUT_MS   = 1600;    // 1.6sec default timeout
	// k per nF, in tenths of ms: 27 at 3V, 16.2 at 5V
	localparam int K3V_TENTHS       = 270;
	localparam int K5V_TENTHS       = 162;
	localparam int CAP_MIN_PF       = 4700;    // caps above 4.7nF
	localparam int CAP_DEF_NF       = 100;     // plain default cap value

	// derived counts: least times round up, longest round down
	localparam int PULSE_CYC        = PULSE_US * 1000 / CLK_NS;
	localparam int FAULT_DELAY_CYC  = (FAULT_DELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int WRITE_HOLD_CYC   = WRITE_HOLD_NS / CLK_NS;
	localparam int KICK_MIN_CYC     = (KICK_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam longint DEF_TIMEOUT_CYC = longint'(DEF_TIMEOUT_MS) * 64'd100_000;
	localparam longint CAP_TIMEOUT_CYC =
		longint'(K5V_TENTHS) * CAP_DEF_NF * 64'd10_000;

	// ===========================================================
	// output bundle of the gate
	typedef struct packed {
		logic ce_out_drv;   // path drives the chip-select output
		logic ce_out_pu;    // active pull-up on the chip-select output
		logic ce_in_hiz;    // chip-select input presented high-impedance
	} wdg_gate_s;

	// watchdog states
	typedef enum logic [2:0] {
		WDG_RUN   = 3'b001,
		WDG_PULSE = 3'b010,
		WDG_WAIT  = 3'b100
	} wdg_state_e;

endpackage

// ===== hw/wdg_ce_gate.sv
// chip-select gate: passes chip-select while out of reset, blocks it in reset
// assumes sys_rst comes synchronous from the reset generator outside
`timescale 1ns/1ns
module wdg_ce_gate
	import wdg_pkg::*;
#(
	parameter int HOLD_CYC = WRITE_HOLD_CYC
)
(
	// clock and reset
	input  wire logic      clk,
	input  wire logic      rst,
	// control
	input  wire logic      sys_rst,
	input  wire logic      ce_in_n,
	// gate outputs
	output logic           ce_out_n_ff,
	output wdg_gate_s      gate_ff
);

	initial begin
		if (HOLD_CYC < 1 || HOLD_CYC > 65535)
			$error("hold count out of range");
	end

	logic        open_ff;
	logic        nxt_open;
	logic [15:0] hold_ff;

	// ===========================================================
	// path open decision
	always_comb
	begin
		nxt_open = open_ff;
		if (!sys_rst)
			nxt_open = 1'b1;                     // see (R9)
		else if (open_ff && (ce_in_n || hold_ff == 16'(HOLD_CYC - 1)))
			nxt_open = 1'b0;                     // see (R10) see (R11)
	end

	// path open stays low through power-up until reset drops
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			open_ff <= 1'b0;                     // see (R12)
		else
			open_ff <= nxt_open;
	end

	// write completion counter from the start of reset
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			hold_ff <= 16'h0000;
		else if (!sys_rst || !open_ff)
			hold_ff <= 16'h0000;
		else
			hold_ff <= hold_ff + 16'h0001;
	end

	// registered pin drive; pull-up only while blocked
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ce_out_n_ff <= 1'b1;
			gate_ff     <= '{ce_out_drv: 1'b0, ce_out_pu: 1'b1, ce_in_hiz: 1'b1};
		end
		else
		begin
			ce_out_n_ff        <= nxt_open ? ce_in_n : 1'b1;
			gate_ff.ce_out_drv <= nxt_open;
			gate_ff.ce_out_pu  <= !nxt_open;     // see (R13)
			gate_ff.ce_in_hiz  <= !nxt_open;     // see (R9)
		end
	end

endmodule // wdg_ce_gate

// ===== hw/wdg_top.sv
// watchdog with prewarn pulse and fault output, plus chip-select gate
// assumes synchronous inputs and an outside reset generator driving sys_rst
//
// Summary of operation
// (R1) timeout with no kick drives prewarn pulse low for 1.7ms
// (R2) fault output falls 70ns after the prewarn pulse falls
// (R3) further timeouts keep fault low and repeat the prewarn pulse
// (R4) a kick while fault is low restarts timer and raises fault
// (R5) outside flip-flop latches reset after two successive faults
// (R6) select tied high chooses the 1.6sec default timeout
// (R7) capacitor timeout is k ms per nF, k 27 or 16.2
// (R8) system never floats or grounds select; ties high if unused
// (R9) chip-select passes out of reset, blocked with input high-z in reset
// (R10) input high at reset blocks the path at once
// (R11) input low at reset holds path until it rises or 15us
// (R12) power-up keeps path blocked until reset deasserts
// (R13) blocked path pulls the output high; pull-up off when open
// (R14) reset clears counters and drives fault and prewarn high
// (R15) any kick level change or 100ns pulse restarts the timer
// (R16) below reset threshold watchdog is off and fault high
// (R17) all intervals are counted clock cycles set by parameters
`timescale 1ns/1ns
module wdg_top
	import wdg_pkg::*;
#(
	parameter longint DEF_CYC   = DEF_TIMEOUT_CYC,
	parameter longint CAP_CYC   = CAP_TIMEOUT_CYC,
	parameter int     PULSE_LEN = PULSE_CYC,
	parameter int     FAULT_DLY = FAULT_DELAY_CYC,
	parameter int     HOLD_CYC  = WRITE_HOLD_CYC
)
(
	// clock and reset
	input  wire logic  clk,
	input  wire logic  rst,
	// supervisor reset, high while system reset is asserted
	input  wire logic  sys_rst,
	// watchdog pins
	input  wire logic  watchdog_kick,
	input  wire logic  timeout_period_select,
	output logic       timeout_prewarn_pulse_n,
	output logic       watchdog_fault_n,
	// chip-select pins
	input  wire logic  ce_in_n,
	output logic       ce_out_n,
	output logic       ce_out_oe,
	output logic       ce_out_pullup,
	output logic       ce_in_hiz
);

	// counter widths; the counts below must fit them
	localparam int TMO_W  = 40;
	localparam int PCNT_W = 24;

	// ===========================================================
	// elaboration checks
	// the fault edge is timed by the pulse counter, so it must fall
	// inside the pulse, and the pulse must end before the next period
	initial
	begin
		if (DEF_CYC < 2 || CAP_CYC < 2 || PULSE_LEN < 1 || FAULT_DLY < 1)
			$error("watchdog counts out of range");
		if (longint'(PULSE_LEN) + FAULT_DLY >= DEF_CYC)
			$error("pulse must end inside timeout");
		if (longint'(PULSE_LEN) + FAULT_DLY >= CAP_CYC)
			$error("pulse must end inside capacitor timeout");
		if (DEF_CYC >= (64'd1 << TMO_W) || CAP_CYC >= (64'd1 << TMO_W))
			$error("timeout does not fit the counter");
		if (longint'(PULSE_LEN) >= (64'd1 << PCNT_W))
			$error("pulse does not fit its counter");
		if (FAULT_DLY > PULSE_LEN)
			$error("fault must fall inside the pulse");
	end

	wdg_state_e  state_ff;
	logic [39:0] tmo_ff;
	logic [39:0] limit;
	logic [23:0] pcnt_ff;
	logic        kick_ff;
	logic        kick_seen;
	logic        pulse_n_ff;
	logic        fault_n_ff;
	logic        fault_go;
	logic        expired;
	wdg_gate_s   gate;

	// end of a watchdog period; one decode shared by the counter,
	// the state machine and the pulse so they can never disagree
	function automatic logic period_end(
		input logic [39:0] count,
		input logic [39:0] lim
	);
		period_end = count >= lim - 40'h1;
	endfunction

	// ===========================================================
	// timeout select and kick detection
	assign expired   = period_end(tmo_ff, limit);
	assign limit     = timeout_period_select ? DEF_CYC[39:0]   // see (R6)
		: CAP_CYC[39:0];                          // see (R7) see (R17)
	// any level change, so a pulse of one cycle or more counts
	assign kick_seen = watchdog_kick != kick_ff;  // see (R15)
	assign fault_go  = state_ff == WDG_PULSE && pcnt_ff == 24'(FAULT_DLY - 1);

	// previous kick level
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			kick_ff <= 1'b0;
		else
			kick_ff <= watchdog_kick;
	end

	// timeout counter, cleared by kick or system reset
	// it wraps by itself at the period end, so repeated pulses
	// follow one full period apart while the kick stays quiet
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			tmo_ff <= 40'h0;
		else if (sys_rst || kick_seen)
			tmo_ff <= 40'h0;                      // see (R14) see (R15) see (R16)
		else if (expired)
			tmo_ff <= 40'h0;                      // restart for next period (R3 repeat)
		else
			tmo_ff <= tmo_ff + 40'h1;
	end

	// ===========================================================
	// state machine: run, then prewarn pulse, then wait
	// a kick inside the pulse does not cut it short; the pulse
	// runs its full length unless system reset ends it, so an outside flop sees a clean edge
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_ff <= WDG_RUN;
			pcnt_ff  <= 24'h0;
		end
		else if (sys_rst)
		begin
			state_ff <= WDG_RUN;                  // see (R14)
			pcnt_ff  <= 24'h0;
		end
		else
		begin
			unique case (state_ff)
				WDG_RUN:
				begin
					pcnt_ff <= 24'h0;
					if (!kick_seen && expired)
						state_ff <= WDG_PULSE;        // see (R1) see (R3)
				end
				WDG_PULSE:
				begin
					pcnt_ff <= pcnt_ff + 24'h1;
					if (pcnt_ff == 24'(PULSE_LEN - 1))
						state_ff <= WDG_WAIT;         // see (R1)
				end
				WDG_WAIT:
				begin
					pcnt_ff <= 24'h0;
					if (!kick_seen && expired)
						state_ff <= WDG_PULSE;        // see (R3)
					else if (kick_seen)
						state_ff <= WDG_RUN;
				end
			endcase
		end
	end

	// prewarn pulse output, low only in pulse state
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pulse_n_ff <= 1'b1;
		else if (sys_rst)
			pulse_n_ff <= 1'b1;                   // see (R14) see (R16)
		else if (state_ff == WDG_PULSE && pcnt_ff == 24'(PULSE_LEN - 1))
			pulse_n_ff <= 1'b1;
		else if (state_ff != WDG_PULSE && !kick_seen && expired)
			pulse_n_ff <= 1'b0;                   // see (R1)
	end

	// fault output, falls after the pulse edge, rises on kick
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			fault_n_ff <= 1'b1;
		else if (sys_rst)
			fault_n_ff <= 1'b1;                   // see (R14) see (R16)
		else if (kick_seen)
			fault_n_ff <= 1'b1;                   // see (R4)
		else if (fault_go)
			fault_n_ff <= 1'b0;                   // see (R2) see (R3)
	end

	// registered pins
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			timeout_prewarn_pulse_n <= 1'b1;
			watchdog_fault_n        <= 1'b1;
		end
		else
		begin
			timeout_prewarn_pulse_n <= pulse_n_ff;
			watchdog_fault_n        <= fault_n_ff;
		end
	end

	// ===========================================================
	// chip-select gate
	wdg_ce_gate #(
		.HOLD_CYC (HOLD_CYC)
	) u_gate (
		.clk         (clk),
		.rst         (rst),
		.sys_rst     (sys_rst),
		.ce_in_n     (ce_in_n),
		.ce_out_n_ff (ce_out_n),
		.gate_ff     (gate)
	);

	assign ce_out_oe     = gate.ce_out_drv;
	assign ce_out_pullup = gate.ce_out_pu;
	assign ce_in_hiz     = gate.ce_in_hiz;

endmodule // wdg_top

// ===== test/wdg_monitor.sv
// checker on the watchdog and chip-select ports
// assumes a bind into wdg_top, which hands on its counts
`timescale 1ns/1ns
module wdg_monitor #(
	parameter int PULSE_LEN = 20,
	parameter int FAULT_DLY = 7,
	parameter int HOLD_CYC  = 10
)
(
	// clock and resets
	input wire logic clk,
	input wire logic rst,
	input wire logic sys_rst,
	// watchdog
	input wire logic watchdog_kick,
	input wire logic timeout_prewarn_pulse_n,
	input wire logic watchdog_fault_n,
	// chip-select
	input wire logic ce_in_n,
	input wire logic ce_out_n,
	input wire logic ce_out_oe,
	input wire logic ce_out_pullup,
	input wire logic ce_in_hiz
);
	localparam int PW = PULSE_LEN - 1;
	// ==========================================
	// relations between the ports
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_pulse_width: assert property (disable iff (rst || sys_rst)
		$fell(timeout_prewarn_pulse_n) |->
		##PW !timeout_prewarn_pulse_n ##1 timeout_prewarn_pulse_n) else $error("pulse width");
	a_fault_lag: assert property (disable iff (rst || sys_rst)
		$fell(timeout_prewarn_pulse_n) && watchdog_fault_n |-> ##FAULT_DLY !watchdog_fault_n)
		else $error("fault lag");
	a_rst_clear: assert property (
		sys_rst [*3] |-> timeout_prewarn_pulse_n && watchdog_fault_n) else $error("not cleared");
	a_kick_restore: assert property (disable iff (rst || sys_rst)
		!watchdog_fault_n && $changed(watchdog_kick) |-> ##[1:3] watchdog_fault_n)
		else $error("kick ignored");
	a_pass_thru: assert property (
		ce_out_oe |-> ce_out_n == $past(ce_in_n)) else $error("no pass");
	a_block_pull: assert property (
		ce_out_pullup == !ce_out_oe && ce_in_hiz == ce_out_pullup && (ce_out_oe || ce_out_n))
		else $error("pull-up wrong");
	a_fast_block: assert property (
		$rose(sys_rst) && ce_in_n |=> !ce_out_oe) else $error("late block");
	a_write_hold: assert property (
		$rose(sys_rst) && !ce_in_n && ce_out_oe |=> ce_out_oe ##[0:HOLD_CYC] !ce_out_oe)
		else $error("write hold");
	a_stay_block: assert property (
		sys_rst && !ce_out_oe |=> !ce_out_oe) else $error("path reopened");
endmodule // wdg_monitor

bind wdg_top wdg_monitor #(.PULSE_LEN(PULSE_LEN), .FAULT_DLY(FAULT_DLY), .HOLD_CYC(HOLD_CYC))
	u_mon (.clk(clk), .rst(rst), .sys_rst(sys_rst), .watchdog_kick(watchdog_kick),
	.timeout_prewarn_pulse_n(timeout_prewarn_pulse_n), .watchdog_fault_n(watchdog_fault_n),
	.ce_in_n(ce_in_n), .ce_out_n(ce_out_n), .ce_out_oe(ce_out_oe),
	.ce_out_pullup(ce_out_pullup), .ce_in_hiz(ce_in_hiz));

// ===== test/wdg_host.sv
// host model: kicks the watchdog, latches reset on two faults
// assumes the block's clock and reset
`timescale 1ns/1ns
module wdg_host (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic kick_en,
	input  wire logic pulse_n,
	input  wire logic fault_n,
	output logic      kick,
	output logic      manual_reset_n
);
	logic [4:0] gap_ff;
	// level change every 32 cycles, well inside a period
	always_ff @(posedge clk or posedge rst)
	begin
		gap_ff <= rst ? 5'h00 : gap_ff + 5'h01;
		if (rst)
			kick <= 1'b0;
		else if (kick_en && gap_ff == 5'h1F)
			kick <= !kick;
	end
	// flop clocked by the pulse, samples the fault level
	always_ff @(negedge pulse_n or posedge rst)
	begin
		manual_reset_n <= rst ? 1'b1 : fault_n;
	end
endmodule // wdg_host

// ===== test/tb.sv
// testbench: timeouts, kicks and chip-select gating
// assumes the host model and the bound checker
`timescale 1ns/1ns
module tb;
	localparam int DEF = 200;
	localparam int CAP = 150;
	logic clk = 1'b0, rst = 1'b0, sys_rst = 1'b1, kick_en = 1'b0, sel = 1'b1;
	logic ce_in_n = 1'b1;
	logic kick, p_n, f_n, ce_o, oe, pu, hiz, mr_n;
	logic [6:0] obs;
	int err_total = 0, tests_run = 0, cyc = 0, last_kick = 0, seed = 32'h1900, lag;
	int exp_q[$];
	always #5 clk = !clk;
	assign obs = {p_n, f_n, oe, pu, hiz, mr_n, ce_o};
	wdg_top #(.DEF_CYC(DEF), .CAP_CYC(CAP), .PULSE_LEN(20), .FAULT_DLY(7), .HOLD_CYC(10))
	u_dut (.clk(clk), .rst(rst), .sys_rst(sys_rst), .watchdog_kick(kick),
		.timeout_period_select(sel), .timeout_prewarn_pulse_n(p_n), .watchdog_fault_n(f_n),
		.ce_in_n(ce_in_n), .ce_out_n(ce_o), .ce_out_oe(oe), .ce_out_pullup(pu),
		.ce_in_hiz(hiz));
	wdg_host u_host (.clk(clk), .rst(rst), .kick_en(kick_en), .pulse_n(p_n),
		.fault_n(f_n), .kick(kick), .manual_reset_n(mr_n));
	// ==========================================
	// compare, report, finish
	// outputs are looked at mid-cycle, where they have settled
	task automatic check(logic [6:0] exp);
		@(negedge clk);
		tests_run++;
		if (obs !== exp)
		begin
			err_total++;
			$display("unexpected at %0t got %h exp %h", $time, obs, exp);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// cycle count and hang limit
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc > 3000)
		begin
			err_total++;
			complete_run();
		end
	end
	always @(kick) last_kick = cyc;
	// each pulse fall takes the oldest noted time, 0 to 7 cycles late
	always @(negedge p_n)
	begin
		tests_run++;
		lag = (exp_q.size() > 0) ? cyc - exp_q.pop_front() : -1;
		if (lag < 0 || lag > 7)
		begin
			err_total++;
			$display("unexpected pulse at %0t lag %h exp %h", $time, lag, 32'h0);
		end
	end
	// ==========================================
	// main sequence
	initial
	begin
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		check(7'h6F);
		@(posedge clk);
		sys_rst <= 1'b0;
		kick_en <= 1'b1;
		repeat (300)
		begin
			@(posedge clk);
			ce_in_n <= 1'($random(seed));
		end
		@(posedge clk);
		ce_in_n <= 1'b0;
		@(posedge clk);
		check(7'h72);
		$display("kicked run done");
		@(posedge clk);
		kick_en <= 1'b0;
		sel <= 1'b1;
		repeat (2) @(posedge clk);
		exp_q.push_back(last_kick + DEF);
		exp_q.push_back(last_kick + 2 * DEF);
		repeat (DEF + 40) @(posedge clk);
		check(7'h52);
		repeat (DEF) @(posedge clk);
		check(7'h50);
		$display("default timeout done");
		@(posedge clk);
		sel <= 1'b0;
		kick_en <= 1'b1;
		repeat (40) @(posedge clk);
		check(7'h70);
		@(posedge clk);
		kick_en <= 1'b0;
		repeat (2) @(posedge clk);
		exp_q.push_back(last_kick + CAP);
		repeat (CAP + 40) @(posedge clk);
		check(7'h52);
		$display("capacitor timeout done");
		@(posedge clk);
		ce_in_n <= 1'b0;
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (3) @(posedge clk);
		check(7'h72);
		repeat (12) @(posedge clk);
		check(7'h6F);
		@(posedge clk);
		sys_rst <= 1'b0;
		ce_in_n <= 1'b1;
		repeat (4) @(posedge clk);
		check(7'h73);
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		check(7'h6F);
		repeat (20)
		begin
			@(posedge clk);
			ce_in_n <= 1'($random(seed));
		end
		check(7'h6F);
		$display("gating done");
		complete_run();
	end
endmodule // tb
